/* File: dv/pps_pd_model.sv */
// pps_pd_model.sv: cable load as seen by the sequencer front end
// assumes: bench picks the load kind; outputs move at the falling edge
`timescale 1ns/1ps
module pps_pd_model (
    // clock and port control
    input wire i_clk,
    input wire i_det,
    input wire i_cls,
    // load choice: 0 good, 1 open, 2 bad, 3 large cap
    input wire i_on,
    input wire [1:0] i_kind,
    input wire [2:0] i_class,
    // measured results
    output wire o_valid,
    output wire o_open,
    output wire o_short,
    output wire o_cap,
    output wire [2:0] o_class,
    output wire o_mps
);
    reg tog_reg = 1'b0;
    reg [8:0] ph_reg = 9'h000;
    always @(negedge i_clk) begin
        tog_reg <= ~tog_reg;
        ph_reg <= (ph_reg == 9'h18F) ? 9'h000 : ph_reg + 9'h001;
    end
    // outside its window a result line shows a changing pattern
    assign o_valid = i_det ? (i_kind == 2'h0) : tog_reg;
    assign o_open = i_det ? (i_kind == 2'h1) : tog_reg;
    assign o_short = i_det ? 1'b0 : tog_reg;
    assign o_cap = i_det ? (i_kind == 2'h3) : tog_reg;
    assign o_class = i_cls ? i_class : {3{tog_reg}};
    assign o_mps = i_on && (ph_reg < 9'h064);
endmodule // pps_pd_model

/* File: dv/pps_sequencer_chk.sv */
// pps_sequencer_chk.sv: port level assertions for the port sequencer
// assumes: bound to pps_sequencer, one clock, synchronous reset
`timescale 1ns/1ps
`include "pps_regs.vh"
module pps_sequencer_chk #(
    parameter TICK_CYCLES = 4
) (
    // clock, reset, straps, budget pin and overcurrent
    input wire i_clk,
    input wire i_srst,
    input wire i_shutdown_n,
    input wire [1:0] i_legacy_mode,
    input wire i_class_limit_enforce,
    input wire i_ac_sense_oscillator_tied,
    input wire i_single_supply,
    input wire i_power_budget_sense_high,
    input wire i_overcurrent,
    // design outputs
    input wire o_detect_en,
    input wire o_legacy_cap_test,
    input wire o_force_power_on,
    input wire o_port_on,
    input wire o_ac_sense_en,
    input wire [2:0] o_budget_class,
    input wire [2:0] o_cut_class,
    input wire o_led_oe,
    input wire [2:0] o_state,
    input wire [2:0] o_fault,
    input wire [2:0] o_class
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ***************************************************
    // properties
    // ***************************************************
    led_on_a: assert property (
        o_port_on && $past(o_port_on) && !i_single_supply
        && !$past(i_single_supply) |-> o_led_oe)
        else $error("indicator not pulled while powered");
    legacy_cap_a: assert property (
        o_legacy_cap_test |-> o_detect_en
        && $past(i_legacy_mode) == `PPS_LEG_HIGH)
        else $error("capacitance test outside legacy detect");
    force_on_a: assert property (
        i_legacy_mode == `PPS_LEG_FLOAT
        && $past(i_legacy_mode) == `PPS_LEG_FLOAT |-> o_force_power_on)
        else $error("force power mode missing");
    budget_refuse_a: assert property (
        $rose(o_port_on) |-> !$past(i_power_budget_sense_high))
        else $error("port powered with budget pin high");
    budget_class_a: assert property (
        o_port_on && $past(o_port_on) |-> o_budget_class == o_class)
        else $error("budget class differs from stored class");
    dc_mode_a: assert property (
        i_ac_sense_oscillator_tied && $past(i_ac_sense_oscillator_tied)
        |-> !o_ac_sense_en)
        else $error("ac sensing on with oscillator tied");
    shut_off_a: assert property (
        !i_shutdown_n [*3] |-> !o_port_on && !o_detect_en
        && o_state == `PPS_ST_SHUT)
        else $error("activity while shut down");
    cut_base_a: assert property (
        !i_class_limit_enforce && !$past(i_class_limit_enforce)
        |-> o_cut_class == `PPS_CLASS0)
        else $error("cut class not base with enforcement off");
    class_clip_a: assert property (
        o_class <= `PPS_CLASS_MAX)
        else $error("stored class above three");
    cut_off_a: assert property (
        o_port_on && i_overcurrent |-> ##[1:2] !o_port_on)
        else $error("port left on after overcurrent");
    detect_order_a: assert property (
        $rose(o_detect_en) |-> $past(o_state) == `PPS_ST_WAIT)
        else $error("detection not entered from wait");
    power_up_c: cover property ($rose(o_port_on));
    overcur_c: cover property (o_fault == `PPS_FLT_OVERCUR);
    budget_c: cover property (o_fault == `PPS_FLT_BUDGET);
endmodule // pps_sequencer_chk

bind pps_sequencer pps_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_shutdown_n(i_shutdown_n),
    .i_legacy_mode(i_legacy_mode),
    .i_class_limit_enforce(i_class_limit_enforce),
    .i_ac_sense_oscillator_tied(i_ac_sense_oscillator_tied),
    .i_single_supply(i_single_supply),
    .i_power_budget_sense_high(i_power_budget_sense_high),
    .i_overcurrent(i_overcurrent), .o_detect_en(o_detect_en),
    .o_legacy_cap_test(o_legacy_cap_test),
    .o_force_power_on(o_force_power_on), .o_port_on(o_port_on),
    .o_ac_sense_en(o_ac_sense_en), .o_budget_class(o_budget_class),
    .o_cut_class(o_cut_class), .o_led_oe(o_led_oe), .o_state(o_state),
    .o_fault(o_fault), .o_class(o_class));

/* File: dv/test_pps_sequencer.sv */
// test_pps_sequencer.sv: scenario bench for the port sequencer
// assumes: pps_pd_model is the load; short tick of T clock cycles
`timescale 1ns/1ps
`include "pps_regs.vh"
module test_pps_sequencer;
    localparam T = 2;
    reg i_clk = 1'b0;
    reg i_srst = 1'b1;
    reg i_shutdown_n = 1'b1;
    reg [1:0] i_legacy_mode = 2'h0;
    reg i_midspan_en = 1'b0, i_class_limit_enforce = 1'b1;
    reg i_ac_sense_oscillator_tied = 1'b1, i_single_supply = 1'b0;
    reg i_power_budget_sense_high = 1'b0, i_overcurrent = 1'b0;
    reg present = 1'b1;
    reg [1:0] kind = 2'h0;
    wire i_sig_valid, i_sig_open, i_sig_short, i_sig_large_cap, mps;
    wire [2:0] i_class_raw, o_budget_class, o_cut_class;
    wire [2:0] o_state, o_fault, o_class;
    wire o_detect_en, o_legacy_cap_test, o_force_power_on, o_classify_en;
    wire o_port_on, o_ac_sense_en, o_led_out, o_led_oe;
    integer err_count = 0, cmp_count = 0, n, m, i;
    always #2 i_clk = ~i_clk;
    pps_sequencer #(.TICK_CYCLES(T)) u_pps_sequencer (
        .i_clk(i_clk), .i_srst(i_srst), .i_shutdown_n(i_shutdown_n),
        .i_legacy_mode(i_legacy_mode), .i_midspan_en(i_midspan_en),
        .i_class_limit_enforce(i_class_limit_enforce),
        .i_ac_sense_oscillator_tied(i_ac_sense_oscillator_tied),
        .i_single_supply(i_single_supply), .i_sig_valid(i_sig_valid),
        .i_sig_open(i_sig_open), .i_sig_short(i_sig_short),
        .i_sig_large_cap(i_sig_large_cap),
        .i_sig_force_range(i_sig_large_cap), .i_class_raw(i_class_raw),
        .i_power_budget_sense_high(i_power_budget_sense_high),
        .i_overcurrent(i_overcurrent), .i_ac_sense_output_cap_ok(mps),
        .i_dc_mps_present(mps), .o_detect_en(o_detect_en),
        .o_legacy_cap_test(o_legacy_cap_test),
        .o_force_power_on(o_force_power_on), .o_classify_en(o_classify_en),
        .o_port_on(o_port_on), .o_ac_sense_en(o_ac_sense_en),
        .o_budget_class(o_budget_class), .o_cut_class(o_cut_class),
        .o_led_out(o_led_out), .o_led_oe(o_led_oe), .o_state(o_state),
        .o_fault(o_fault), .o_class(o_class));
    pps_pd_model u_pps_pd_model (
        .i_clk(i_clk), .i_det(o_detect_en), .i_cls(o_classify_en),
        .i_on(present), .i_kind(kind), .i_class(3'h5),
        .o_valid(i_sig_valid), .o_open(i_sig_open), .o_short(i_sig_short),
        .o_cap(i_sig_large_cap), .o_class(i_class_raw), .o_mps(mps));
    task chk(input [8*12:1] nm, input [31:0] e, input [31:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("ERROR %0s exp %0h got %0h", nm, e, g);
            end
        end
    endtask
    task chk_near(input [8*12:1] nm, input integer e, input integer g);
        begin
            cmp_count = cmp_count + 1;
            if (g < e - 4 || g > e + 4) begin
                err_count = err_count + 1;
                $display("ERROR %0s exp %0d got %0d", nm, e, g);
            end
        end
    endtask
    // counts falling edges until the state is reached
    task wait_st(input [2:0] s, input integer lim, output integer c);
        begin
            c = 0;
            while (o_state !== s && c < lim) begin
                @(negedge i_clk);
                c = c + 1;
            end
            if (c >= lim) begin
                err_count = err_count + 1;
                $display("ERROR state exp %0h got %0h", s, o_state);
            end
        end
    endtask
    task t_power_up;
        begin
            wait_st(`PPS_ST_CLASS, 9000, n);
            chk("classify_en", 1, o_classify_en);
            wait_st(`PPS_ST_POWERED, 600, n);
            chk_near("turn_on", 145 * T, n);
            @(negedge i_clk);
            chk("led_oe", 1, o_led_oe);
            chk("led_out", 0, o_led_out);
            chk("class", `PPS_CLASS3, o_class);
            chk("budget_cls", `PPS_CLASS3, o_budget_class);
            chk("cut_cls", `PPS_CLASS3, o_cut_class);
        end
    endtask
    task t_overcurrent;
        begin
            i_class_limit_enforce = 1'b0;
            i_overcurrent = 1'b1;
            repeat (2) @(negedge i_clk);
            i_overcurrent = 1'b0;
            chk("port_on", 0, o_port_on);
            chk("fault", `PPS_FLT_OVERCUR, o_fault);
            // one full flash period: one on slot of six
            m = 0;
            for (i = 0; i < 3000; i = i + 1) begin
                @(negedge i_clk);
                m = m + o_led_oe;
            end
            chk("flash_on", 250 * T, m);
            wait_st(`PPS_ST_DETECT, 5400, n);
            chk_near("err_delay", 4000 * T, n + 3000);
            wait_st(`PPS_ST_POWERED, 1200, n);
            @(negedge i_clk);
            chk("cut_cls", `PPS_CLASS0, o_cut_class);
        end
    endtask
    task t_disconnect;
        begin
            i_ac_sense_oscillator_tied = 1'b0;
            repeat (2) @(negedge i_clk);
            chk("ac_sense_en", 1, o_ac_sense_en);
            m = 0;
            while (mps !== 1'b1 && m < 500) begin
                @(negedge i_clk);
                m = m + 1;
            end
            present = 1'b0;
            wait_st(`PPS_ST_WAIT, 1000, n);
            chk_near("loss_time", 350 * T, n);
            chk("fault", `PPS_FLT_NONE, o_fault);
            present = 1'b1;
        end
    endtask
    task t_retry;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                kind = (i == 2) ? 2'h1 : 2'h2;
                i_midspan_en = (i != 1);
                wait_st(`PPS_ST_DETECT, 7000, n);
                wait_st(`PPS_ST_WAIT, 1000, n);
                wait_st(`PPS_ST_DETECT, 7000, n);
                chk_near("retry", (i == 0) ? 3200 * T : 580 * T, n);
            end
        end
    endtask
    task t_budget;
        begin
            kind = 2'h0;
            i_power_budget_sense_high = 1'b1;
            wait_st(`PPS_ST_TURNON, 1000, n);
            wait_st(`PPS_ST_WAIT, 600, n);
            chk("port_on", 0, o_port_on);
            chk("fault", `PPS_FLT_BUDGET, o_fault);
            wait_st(`PPS_ST_DETECT, 1300, n);
            chk_near("budget_wait", 580 * T, n);
            i_power_budget_sense_high = 1'b0;
            wait_st(`PPS_ST_POWERED, 1000, n);
            chk("fault", `PPS_FLT_NONE, o_fault);
        end
    endtask
    task t_shutdown;
        begin
            i_single_supply = 1'b1;
            repeat (4) @(negedge i_clk);
            m = 0;
            for (i = 0; i < 100; i = i + 1) begin
                @(negedge i_clk);
                m = m + o_led_oe;
            end
            chk("led_duty", 6, m);
            i_single_supply = 1'b0;
            i_shutdown_n = 1'b0;
            i_legacy_mode = `PPS_LEG_FLOAT;
            repeat (3) @(negedge i_clk);
            chk("port_on", 0, o_port_on);
            chk("force_on", 1, o_force_power_on);
            repeat (200) @(negedge i_clk);
            chk("detect_en", 0, o_detect_en);
            chk("state", `PPS_ST_SHUT, o_state);
            i_legacy_mode = `PPS_LEG_HIGH;
            i_shutdown_n = 1'b1;
            wait_st(`PPS_ST_DETECT, 8400, n);
            chk_near("sd_delay", 4000 * T, n);
            chk("cap_test", 1, o_legacy_cap_test);
            kind = 2'h3;
            wait_st(`PPS_ST_CLASS, 700, n);
            chk("legacy_acc", `PPS_ST_CLASS, o_state);
            i_legacy_mode = `PPS_LEG_LOW;
        end
    endtask
    task finish_test;
        begin
            if (err_count == 0 && cmp_count > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        #240000;
        err_count = err_count + 1;
        finish_test;
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        t_power_up;
        t_overcurrent;
        t_disconnect;
        t_retry;
        t_budget;
        t_shutdown;
        finish_test;
    end
endmodule // test_pps_sequencer

/* File: src/pps_regs.vh */
// pps_regs.vh: constants of the port power sequencer
// assumes: included once per compile unit by its bare name
`ifndef PPS_REGS_VH
`define PPS_REGS_VH

// ***************************************************
// clock and timing
// ***************************************************
`define PPS_CLK_PERIOD_NS 4
`define PPS_TICK_NS 1000000
`define PPS_DET_MS 13'h0122
`define PPS_CLS_MS 13'h0025
`define PPS_PON_MS 13'h0091
`define PPS_RETRY_MS 13'h0244
`define PPS_BACKOFF_MS 13'h0C80
`define PPS_ERR_MS 13'h0FA0
`define PPS_SD_MS 13'h0FA0
`define PPS_MPDO_MS 13'h015E
`define PPS_FLASH_SLOT_MS 8'hFA

// ***************************************************
// indicator pulse train for single supply
// ***************************************************
`define PPS_PWM_PERIOD 7'h64
`define PPS_PWM_ON 7'h06

// ***************************************************
// legacy strap encodings
// ***************************************************
`define PPS_LEG_LOW 2'h0
`define PPS_LEG_HIGH 2'h1
`define PPS_LEG_FLOAT 2'h2

// ***************************************************
// sequence states
// ***************************************************
`define PPS_ST_SHUT 3'h0
`define PPS_ST_WAIT 3'h1
`define PPS_ST_DETECT 3'h2
`define PPS_ST_CLASS 3'h3
`define PPS_ST_TURNON 3'h4
`define PPS_ST_POWERED 3'h5

// ***************************************************
// fault codes, also the flash count
// ***************************************************
`define PPS_FLT_NONE 3'h0
`define PPS_FLT_OVERCUR 3'h1
`define PPS_FLT_SIGNATURE 3'h2
`define PPS_FLT_BUDGET 3'h3
`define PPS_FLT_SHORT 3'h4

// ***************************************************
// class values
// ***************************************************
`define PPS_CLASS0 3'h0
`define PPS_CLASS3 3'h3
`define PPS_CLASS_MAX 3'h3

`endif

/* File: src/pps_sequencer.v */
// pps_sequencer.v: single port power sequencer for a power-over-ethernet
// source: detect, classify, budget check, turn-on, disconnect monitoring.
// assumes: analog front end reports measurement results as synchronous
// levels; strap pins already resolved to logic levels.
// Operation
// - indicator pulled low while the port is powered
// - on faults the indicator flashes a count naming the fault kind
// - single high supply: indicator on-time becomes 6% duty low pulses
// - legacy strap high: also accept large capacitance legacy loads
// - legacy strap low: accept only compliant signatures
// - legacy strap floating: force power any 1V to 10V load
// - midspan backoff: 3.2 s wait after failed detect, not open
// - midspan off: no extra wait after failed detect
// - budget pin current reflects class of the powered load
// - refuse turn-on while budget pin above 1V
// - oscillator pin tied low selects dc disconnect sensing
// - ac mode: low capacitance longer than loss window turns off
// - shutdown low: no detection and no port power
// - shutdown low while powered turns the port off
// - shutdown released: wait 4 s before first detection
// - enforcement high: cut threshold follows stored class
// - enforcement low: cut threshold stays at class 0 value
// - class 4 or above is treated as class 3
// - detection repeats every 580 ms, or 3.2 s with backoff
// - classify right after good detect, store the class
// - after overcurrent cut wait 4 s before next detect
// - power applied 145 ms after end of valid detect
`timescale 1ns/1ps
`include "pps_regs.vh"

module pps_sequencer #(
    parameter TICK_CYCLES = `PPS_TICK_NS / `PPS_CLK_PERIOD_NS
) (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // straps
    input wire i_shutdown_n,
    input wire [1:0] i_legacy_mode,
    input wire i_midspan_en,
    input wire i_class_limit_enforce,
    input wire i_ac_sense_oscillator_tied,
    input wire i_single_supply,
    // detection results from front end
    input wire i_sig_valid,
    input wire i_sig_open,
    input wire i_sig_short,
    input wire i_sig_large_cap,
    input wire i_sig_force_range,
    // classification and budget
    input wire [2:0] i_class_raw,
    input wire i_power_budget_sense_high,
    // powered monitoring
    input wire i_overcurrent,
    input wire i_ac_sense_output_cap_ok,
    input wire i_dc_mps_present,
    // front end control
    output reg o_detect_en,
    output reg o_legacy_cap_test,
    output reg o_force_power_on,
    output reg o_classify_en,
    output reg o_port_on,
    output reg o_ac_sense_en,
    output reg [2:0] o_budget_class,
    output reg [2:0] o_cut_class,
    // indicator, open drain
    output reg o_led_out,
    output reg o_led_oe,
    // status
    output reg [2:0] o_state,
    output reg [2:0] o_fault,
    output reg [2:0] o_class
);

    // ***************************************************
    // helpers
    // ***************************************************
    function [2:0] clamp_class;
        input [2:0] raw;
        begin
            clamp_class = (raw > `PPS_CLASS_MAX) ? `PPS_CLASS3 : raw;
        end
    endfunction

    function [12:0] fail_wait;
        input midspan;
        input open_circ;
        begin
            fail_wait = (midspan && !open_circ) ? `PPS_BACKOFF_MS :
                `PPS_RETRY_MS;
        end
    endfunction

    // ***************************************************
    // millisecond tick
    // ***************************************************
    reg [17:0] pre_reg;
    reg tick_reg;

    always @(posedge i_clk) begin
        if (i_srst) begin
            pre_reg <= 18'h0_0000;
            tick_reg <= 1'b0;
        end else if (pre_reg == TICK_CYCLES[17:0] - 18'h0_0001) begin
            pre_reg <= 18'h0_0000;
            tick_reg <= 1'b1;
        end else begin
            pre_reg <= pre_reg + 18'h0_0001;
            tick_reg <= 1'b0;
        end
    end

    // ***************************************************
    // sequence state machine
    // ***************************************************
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [12:0] ms_reg;
    reg [12:0] ms_next;
    reg [12:0] wait_reg;
    reg [12:0] wait_next;
    reg [12:0] loss_reg;
    reg [12:0] loss_next;
    reg [2:0] fault_reg;
    reg [2:0] fault_next;
    reg [2:0] class_reg;
    reg [2:0] class_next;
    reg accept;
    reg sig_present;

    always @* begin
        case (i_legacy_mode)
            `PPS_LEG_HIGH: accept = i_sig_valid | i_sig_large_cap;
            `PPS_LEG_FLOAT: accept = i_sig_valid | i_sig_large_cap |
                i_sig_force_range;
            default: accept = i_sig_valid;
        endcase
        // select dc or ac disconnect sense
        if (i_ac_sense_oscillator_tied) begin
            sig_present = i_dc_mps_present;
        end else begin
            sig_present = i_ac_sense_output_cap_ok;
        end
    end

    always @* begin
        state_next = state_reg;
        ms_next = ms_reg;
        wait_next = wait_reg;
        loss_next = loss_reg;
        fault_next = fault_reg;
        class_next = class_reg;
        if (tick_reg) begin
            ms_next = ms_reg + 13'h0001;
        end
        case (state_reg)
            `PPS_ST_SHUT: begin
                if (i_shutdown_n) begin
                    state_next = `PPS_ST_WAIT;
                    wait_next = `PPS_SD_MS;
                    ms_next = 13'h0000;
                end
            end
            `PPS_ST_WAIT: begin
                if (ms_reg >= wait_reg) begin
                    state_next = `PPS_ST_DETECT;
                    ms_next = 13'h0000;
                end
            end
            `PPS_ST_DETECT: begin
                if (ms_reg >= `PPS_DET_MS) begin
                    ms_next = 13'h0000;
                    if (accept) begin
                        state_next = `PPS_ST_CLASS;
                    end else begin
                        state_next = `PPS_ST_WAIT;
                        wait_next = fail_wait(i_midspan_en, i_sig_open);
                        if (i_sig_short) begin
                            fault_next = `PPS_FLT_SHORT;
                        end else if (!i_sig_open) begin
                            fault_next = `PPS_FLT_SIGNATURE;
                        end
                    end
                end
            end
            `PPS_ST_CLASS: begin
                if (ms_reg >= `PPS_CLS_MS) begin
                    class_next = clamp_class(i_class_raw);
                    state_next = `PPS_ST_TURNON;
                end
            end
            `PPS_ST_TURNON: begin
                // turn-on delay from end of detect
                if (ms_reg >= `PPS_PON_MS) begin
                    ms_next = 13'h0000;
                    if (i_power_budget_sense_high) begin
                        state_next = `PPS_ST_WAIT;
                        wait_next = `PPS_RETRY_MS;
                        fault_next = `PPS_FLT_BUDGET;
                    end else begin
                        state_next = `PPS_ST_POWERED;
                        fault_next = `PPS_FLT_NONE;
                        loss_next = 13'h0000;
                    end
                end
            end
            `PPS_ST_POWERED: begin
                if (sig_present) begin
                    loss_next = 13'h0000;
                end else if (tick_reg) begin
                    loss_next = loss_reg + 13'h0001;
                end
                ms_next = 13'h0000;
                if (i_overcurrent) begin
                    state_next = `PPS_ST_WAIT;
                    wait_next = `PPS_ERR_MS;
                    fault_next = `PPS_FLT_OVERCUR;
                end else if (loss_reg >= `PPS_MPDO_MS) begin
                    state_next = `PPS_ST_WAIT;
                    wait_next = `PPS_RETRY_MS;
                end
            end
            default: begin
                state_next = `PPS_ST_SHUT;
            end
        endcase
        if (!i_shutdown_n) begin
            state_next = `PPS_ST_SHUT;
            ms_next = 13'h0000;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= `PPS_ST_SHUT;
            ms_reg <= 13'h0000;
            wait_reg <= 13'h0000;
            loss_reg <= 13'h0000;
            fault_reg <= `PPS_FLT_NONE;
            class_reg <= `PPS_CLASS0;
        end else begin
            state_reg <= state_next;
            ms_reg <= ms_next;
            wait_reg <= wait_next;
            loss_reg <= loss_next;
            fault_reg <= fault_next;
            class_reg <= class_next;
        end
    end

    // ***************************************************
    // indicator pattern
    // ***************************************************
    reg [7:0] slot_ms_reg;
    reg [3:0] slot_reg;
    reg [6:0] pwm_reg;
    wire slot_end;
    wire [3:0] flash_slots;
    reg led_want;

    assign slot_end = tick_reg && (slot_ms_reg == `PPS_FLASH_SLOT_MS - 8'h01);
    assign flash_slots = {fault_reg, 1'b0} + 4'h4;

    always @(posedge i_clk) begin
        if (i_srst) begin
            slot_ms_reg <= 8'h00;
            slot_reg <= 4'h0;
            pwm_reg <= 7'h00;
        end else begin
            if (slot_end) begin
                slot_ms_reg <= 8'h00;
                if (slot_reg >= flash_slots - 4'h1) begin
                    slot_reg <= 4'h0;
                end else begin
                    slot_reg <= slot_reg + 4'h1;
                end
            end else if (tick_reg) begin
                slot_ms_reg <= slot_ms_reg + 8'h01;
            end
            if (pwm_reg == `PPS_PWM_PERIOD - 7'h01) begin
                pwm_reg <= 7'h00;
            end else begin
                pwm_reg <= pwm_reg + 7'h01;
            end
        end
    end

    always @* begin
        if (state_next == `PPS_ST_POWERED) begin
            led_want = 1'b1;
        end else if (fault_next != `PPS_FLT_NONE) begin
            led_want = (slot_reg < {fault_next, 1'b0}) && !slot_reg[0];
        end else begin
            led_want = 1'b0;
        end
    end

    // ***************************************************
    // registered outputs
    // ***************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_detect_en <= 1'b0;
            o_legacy_cap_test <= 1'b0;
            o_force_power_on <= 1'b0;
            o_classify_en <= 1'b0;
            o_port_on <= 1'b0;
            o_ac_sense_en <= 1'b0;
            o_budget_class <= `PPS_CLASS0;
            o_cut_class <= `PPS_CLASS0;
            o_led_out <= 1'b0;
            o_led_oe <= 1'b0;
            o_state <= `PPS_ST_SHUT;
            o_fault <= `PPS_FLT_NONE;
            o_class <= `PPS_CLASS0;
        end else begin
            o_detect_en <= (state_next == `PPS_ST_DETECT);
            o_legacy_cap_test <= (state_next == `PPS_ST_DETECT) &&
                (i_legacy_mode == `PPS_LEG_HIGH);
            o_force_power_on <= (i_legacy_mode == `PPS_LEG_FLOAT);
            o_classify_en <= (state_next == `PPS_ST_CLASS);
            o_port_on <= (state_next == `PPS_ST_POWERED);
            o_ac_sense_en <= (state_next == `PPS_ST_POWERED) &&
                !i_ac_sense_oscillator_tied;
            if (state_next == `PPS_ST_POWERED) begin
                o_budget_class <= class_next;
            end else begin
                o_budget_class <= `PPS_CLASS0;
            end
            if (i_class_limit_enforce) begin
                o_cut_class <= class_next;
            end else begin
                o_cut_class <= `PPS_CLASS0;
            end
            o_led_out <= 1'b0;
            // duty limited pulses on single supply
            o_led_oe <= led_want &&
                (!i_single_supply || (pwm_reg < `PPS_PWM_ON));
            o_state <= state_next;
            o_fault <= fault_next;
            o_class <= class_next;
        end
    end

endmodule // pps_sequencer
